// File: design/ccs_pkg.sv
// constants, field layout and types for the clock input / pll / spread control block
// How it works
// - byte 11 bits 7:6 pick crystal, single-ended pair or differential input; crystal default.
// - single-ended mode: byte 10 bit 4 picks primary or secondary input, primary default.
// - byte 10 control-pin field set to clock select hands selection to control pin 0.
// - per-PLL speed bit in byte 6 bits 7:5 picks 80-200 or 180-300 MHz VCO.
// - M and N dividers run fractional while the VCO is at or below 250 MHz.
// - PLL bypass routes the selected input straight to output switch A.
// - byte 3 bits 7:5 bypass only the VCO, M divider stays in path.
// - a PLL in VCO bypass is powered down.
// - PLL2 offers spread and plain outputs at the same time.
// - center spread keeps the mean phase equal to the unmodulated clock.
// - amount 000 powers down the spread output, holds it low, plain output runs.
// - center spread deviates symmetrically by 0.1, 0.25 or 0.4 percent.
// - down spread stays at or below the carrier, sweeping downward.
// - sweep rate selectable between about 17.6 and 60 kHz.
// - the sweep follows a triangular profile.
// - amount field: 000 bypass, 001-011 center spread, 100-111 down spread 1-3 percent.
`default_nettype none
package ccs_pkg;
    localparam int CCS_ADDR_W = 5;
    // byte addresses
    localparam logic [4:0] CCS_BYTE_VCO_BYPASS = 5'h03;
    localparam logic [4:0] CCS_BYTE_SPEED = 5'h06;
    localparam logic [4:0] CCS_BYTE_PIN_CFG = 5'h0a;
    localparam logic [4:0] CCS_BYTE_SOURCE = 5'h0b;
    localparam logic [4:0] CCS_BYTE_SPREAD = 5'h19;
    localparam logic [4:0] CCS_BYTE_EXTRA = 5'h1b;
    localparam logic [4:0] CCS_BYTE_STATUS = 5'h1c;
    // field positions
    localparam int CCS_VCO_BYPASS_LSB = 5;
    localparam int CCS_SPEED_LSB = 5;
    localparam int CCS_PIN_CFG_LSB = 0;
    localparam int CCS_INT_SEL_BIT = 4;
    localparam int CCS_SOURCE_LSB = 6;
    localparam int CCS_AMOUNT_LSB = 4;
    localparam int CCS_RATE_LSB = 0;
    localparam int CCS_ABOVE250_LSB = 0;
    localparam int CCS_PLL_BYP_LSB = 3;
    // field codes
    localparam logic [1:0] CCS_SRC_CRYSTAL = 2'h0;
    localparam logic [1:0] CCS_SRC_SINGLE = 2'h1;
    localparam logic [1:0] CCS_SRC_DIFF = 2'h2;
    localparam logic [1:0] CCS_PIN_PLL_BYPASS = 2'h1;
    localparam logic [1:0] CCS_PIN_CLK_SEL = 2'h2;
    localparam logic [2:0] CCS_AMOUNT_BYPASS = 3'h0;
    // reset values
    localparam logic [7:0] CCS_ZERO_RST = 8'h00;
    localparam logic [7:0] CCS_SPREAD_RST = 8'h09;
    // sweep full period in cycles per rate code; triangle half is half of it
    localparam logic [12:0] CCS_RATE_FACTOR [16] = '{
        13'h1630, 13'h1524, 13'h1418, 13'h130c, 13'h1200, 13'h10f4, 13'h0fe8, 13'h0edc,
        13'h0dd0, 13'h0cd6, 13'h0bb8, 13'h0aac, 13'h09a0, 13'h0894, 13'h0788, 13'h067c};
    // deviation in hundredths of a percent per amount code
    localparam logic [8:0] CCS_SPAN_BP [8] = '{
        9'h000, 9'h00a, 9'h019, 9'h028, 9'h064, 9'h096, 9'h0c8, 9'h12c};
    typedef enum logic [1:0] {CCS_SW_IDLE, CCS_SW_RISE, CCS_SW_FALL} ccs_sweep_state_type;
endpackage
`default_nettype wire

// File: design/ccs_sweep_if.sv
// link between the control top and the triangle sweep generator
`default_nettype none
interface ccs_sweep_if;
    logic enable;
    logic [3:0] rate_sel;
    logic [11:0] pos;
    logic [11:0] top;
    logic falling;
    modport ctrl (output enable, output rate_sel, input pos, input top, input falling);
    modport sweep (input enable, input rate_sel, output pos, output top, output falling);
endinterface
`default_nettype wire

// File: design/ccs_regmem.sv
// byte image of the configuration space with registered read data
`default_nettype none
module ccs_regmem #(
    parameter int DEPTH = 28
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // access
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [ccs_pkg::CCS_ADDR_W-1:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic stat_sel,
    input wire logic [7:0] stat_data,
    output logic [7:0] rd_data
);
    logic [7:0] mem_q [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= (i == int'(ccs_pkg::CCS_BYTE_SPREAD)) ?
                    ccs_pkg::CCS_SPREAD_RST : ccs_pkg::CCS_ZERO_RST;
            end
        end else if (ce && wr_en && (int'(addr) < DEPTH)) begin
            mem_q[addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_data <= ccs_pkg::CCS_ZERO_RST;
        end else if (ce && rd_en) begin
            if (stat_sel) begin
                rd_data <= stat_data;
            end else if (int'(addr) < DEPTH) begin
                rd_data <= mem_q[addr];
            end else begin
                rd_data <= ccs_pkg::CCS_ZERO_RST;
            end
        end
    end
endmodule // ccs_regmem
`default_nettype wire

// File: design/ccs_sweep.sv
// triangular spread sweep position generator
`default_nettype none
module ccs_sweep (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // control side
    ccs_sweep_if.sweep sw
);
    ccs_pkg::ccs_sweep_state_type state_q;
    logic [11:0] pos_q;
    logic [11:0] top_q;

    assign sw.pos = pos_q;
    assign sw.top = top_q;
    assign sw.falling = (state_q == ccs_pkg::CCS_SW_FALL);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            top_q <= ccs_pkg::CCS_RATE_FACTOR[ccs_pkg::CCS_SPREAD_RST[3:0]][12:1];
        end else if (ce) begin
            top_q <= ccs_pkg::CCS_RATE_FACTOR[sw.rate_sel][12:1];
        end
    end

    // up one step per cycle to the top, down to zero: symmetric, so mean sits mid-span
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= ccs_pkg::CCS_SW_IDLE;
            pos_q <= 12'h000;
        end else if (ce) begin
            if (!sw.enable) begin
                state_q <= ccs_pkg::CCS_SW_IDLE;
                pos_q <= 12'h000;
            end else begin
                case (state_q)
                    ccs_pkg::CCS_SW_IDLE: begin
                        state_q <= ccs_pkg::CCS_SW_RISE;
                    end
                    ccs_pkg::CCS_SW_RISE: begin
                        if (pos_q >= top_q) begin
                            state_q <= ccs_pkg::CCS_SW_FALL;
                            pos_q <= pos_q - 12'h001;
                        end else begin
                            pos_q <= pos_q + 12'h001;
                            if (pos_q + 12'h001 >= top_q) begin
                                state_q <= ccs_pkg::CCS_SW_FALL;
                            end
                        end
                    end
                    ccs_pkg::CCS_SW_FALL: begin
                        pos_q <= pos_q - 12'h001;
                        if (pos_q == 12'h001) begin
                            state_q <= ccs_pkg::CCS_SW_RISE;
                        end
                    end
                    default: begin
                        state_q <= ccs_pkg::CCS_SW_IDLE;
                    end
                endcase
            end
        end
    end

    sweep_step_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && sw.enable && state_q != ccs_pkg::CCS_SW_IDLE) |=>
        (pos_q == $past(pos_q) + 12'h001 || pos_q == $past(pos_q) - 12'h001))
        else $error("sweep moved by other than one step");

    sweep_bound_a: assert property (@(posedge clk_sys) disable iff (reset)
        (state_q == ccs_pkg::CCS_SW_RISE && ce && sw.enable && pos_q + 12'h001 == top_q
         && $stable(top_q)) |=> (state_q == ccs_pkg::CCS_SW_FALL && pos_q == top_q))
        else $error("sweep did not turn at its top");
endmodule // ccs_sweep
`default_nettype wire

// File: design/ccs_ctrl.sv
// clock input select, pll mode and spread control with its register port
//
// Our own choices: the address-and-strobe port and the address map.
`default_nettype none
module ccs_ctrl (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic ce,
    // register port
    input wire logic [ccs_pkg::CCS_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rd_data,
    // control pin
    input wire logic multi_function_control_pin0,
    // reference input steering
    output logic [1:0] ref_source_mode_q,
    output logic ref_input_select_q,
    // per-pll modes
    output logic [2:0] vco_speed_range_select_q,
    output logic [2:0] fractional_mode_q,
    output logic [2:0] pll_bypass_q,
    output logic [2:0] vco_bypass_select_q,
    output logic [2:0] pll_power_down_q,
    // pll2 outputs and spread
    output logic pll2_plain_enable_q,
    output logic spread_enable_q,
    output logic spread_center_q,
    output logic [8:0] spread_span_q,
    output logic [11:0] spread_pos,
    output logic [11:0] spread_top
);
    logic [1:0] pin_cfg_q;
    logic int_sel_q;
    logic [2:0] above250_q;
    logic [2:0] pll_bypass_cfg_q;
    logic [2:0] spread_amount_q;
    logic [3:0] spread_rate_q;
    logic [7:0] status;
    logic pin_bypass;

    ccs_sweep_if sw ();

    // spread runs only with a nonzero amount and pll2 out of vco bypass, so the
    // bypass-write-release order restarts the triangle cleanly
    assign sw.enable = (spread_amount_q != ccs_pkg::CCS_AMOUNT_BYPASS)
        && !vco_bypass_select_q[1];
    assign sw.rate_sel = spread_rate_q;
    assign spread_pos = sw.pos;
    assign spread_top = sw.top;
    assign pin_bypass = (pin_cfg_q == ccs_pkg::CCS_PIN_PLL_BYPASS) && !multi_function_control_pin0;
    assign status = {spread_enable_q, sw.falling, ref_input_select_q, pll_power_down_q,
        ref_source_mode_q};

    ccs_sweep u_sweep (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .sw(sw.sweep)
    );

    ccs_regmem #(.DEPTH(28)) u_mem (
        .clk_sys(clk_sys),
        .reset(reset),
        .ce(ce),
        .wr_en(reg_wr && reg_addr != ccs_pkg::CCS_BYTE_STATUS),
        .rd_en(reg_rd),
        .addr(reg_addr),
        .wr_data(reg_wr_data),
        .stat_sel(reg_addr == ccs_pkg::CCS_BYTE_STATUS),
        .stat_data(status),
        .rd_data(reg_rd_data)
    );

    // field registers take the write at once and load their defaults on reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ref_source_mode_q <= ccs_pkg::CCS_SRC_CRYSTAL;
            pin_cfg_q <= 2'h0;
            int_sel_q <= 1'b0;
            vco_speed_range_select_q <= 3'h0;
            vco_bypass_select_q <= 3'h0;
            above250_q <= 3'h0;
            pll_bypass_cfg_q <= 3'h0;
            spread_amount_q <= ccs_pkg::CCS_SPREAD_RST[ccs_pkg::CCS_AMOUNT_LSB +: 3];
            spread_rate_q <= ccs_pkg::CCS_SPREAD_RST[ccs_pkg::CCS_RATE_LSB +: 4];
        end else if (ce && reg_wr) begin
            if (reg_addr == ccs_pkg::CCS_BYTE_SOURCE) begin
                ref_source_mode_q <= reg_wr_data[ccs_pkg::CCS_SOURCE_LSB +: 2];
            end else if (reg_addr == ccs_pkg::CCS_BYTE_PIN_CFG) begin
                pin_cfg_q <= reg_wr_data[ccs_pkg::CCS_PIN_CFG_LSB +: 2];
                int_sel_q <= reg_wr_data[ccs_pkg::CCS_INT_SEL_BIT];
            end else if (reg_addr == ccs_pkg::CCS_BYTE_SPEED) begin
                vco_speed_range_select_q <= reg_wr_data[ccs_pkg::CCS_SPEED_LSB +: 3];
            end else if (reg_addr == ccs_pkg::CCS_BYTE_VCO_BYPASS) begin
                vco_bypass_select_q <= reg_wr_data[ccs_pkg::CCS_VCO_BYPASS_LSB +: 3];
            end else if (reg_addr == ccs_pkg::CCS_BYTE_SPREAD) begin
                spread_amount_q <= reg_wr_data[ccs_pkg::CCS_AMOUNT_LSB +: 3];
                spread_rate_q <= reg_wr_data[ccs_pkg::CCS_RATE_LSB +: 4];
            end else if (reg_addr == ccs_pkg::CCS_BYTE_EXTRA) begin
                above250_q <= reg_wr_data[ccs_pkg::CCS_ABOVE250_LSB +: 3];
                pll_bypass_cfg_q <= reg_wr_data[ccs_pkg::CCS_PLL_BYP_LSB +: 3];
            end
        end
    end

    // reference selection: pin only counts when configured as clock select
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ref_input_select_q <= 1'b0;
        end else if (ce) begin
            if (ref_source_mode_q != ccs_pkg::CCS_SRC_SINGLE) begin
                ref_input_select_q <= 1'b0;
            end else if (pin_cfg_q == ccs_pkg::CCS_PIN_CLK_SEL) begin
                ref_input_select_q <= multi_function_control_pin0;
            end else begin
                ref_input_select_q <= int_sel_q;
            end
        end
    end

    // per-pll modes; speed bit alone cannot tell 250 MHz, so software flags it
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fractional_mode_q <= 3'h7;
            pll_bypass_q <= 3'h0;
            pll_power_down_q <= 3'h0;
        end else if (ce) begin
            fractional_mode_q <= ~above250_q;
            pll_bypass_q <= pll_bypass_cfg_q | {3{pin_bypass}};
            pll_power_down_q <= vco_bypass_select_q;
        end
    end

    // pll2 spread path; the plain output ignores the spread amount entirely
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pll2_plain_enable_q <= 1'b1;
            spread_enable_q <= 1'b0;
            spread_center_q <= 1'b1;
            spread_span_q <= 9'h000;
        end else if (ce) begin
            pll2_plain_enable_q <= !vco_bypass_select_q[1];
            spread_enable_q <= sw.enable;
            spread_center_q <= !spread_amount_q[2];
            spread_span_q <= ccs_pkg::CCS_SPAN_BP[spread_amount_q];
        end
    end

    source_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && reg_wr && reg_addr == ccs_pkg::CCS_BYTE_SOURCE) |=>
        (ref_source_mode_q == $past(reg_wr_data[7:6])))
        else $error("source mode not taken from write");

    pin_select_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && ref_source_mode_q == ccs_pkg::CCS_SRC_SINGLE
         && pin_cfg_q == ccs_pkg::CCS_PIN_CLK_SEL) |=>
        (ref_input_select_q == $past(multi_function_control_pin0)))
        else $error("control pin did not steer input select");

    int_select_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && ref_source_mode_q == ccs_pkg::CCS_SRC_SINGLE
         && pin_cfg_q != ccs_pkg::CCS_PIN_CLK_SEL) |=> (ref_input_select_q == $past(int_sel_q)))
        else $error("internal select bit ignored");

    speed_write_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && reg_wr && reg_addr == ccs_pkg::CCS_BYTE_SPEED) |=>
        (vco_speed_range_select_q == $past(reg_wr_data[7:5])))
        else $error("speed range not taken from write");

    vco_power_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && reg_wr && reg_addr == ccs_pkg::CCS_BYTE_VCO_BYPASS) ##1 ce |=>
        (pll_power_down_q == $past(reg_wr_data[7:5], 2)))
        else $error("vco bypass did not power down its pll");

    fraction_mode_a: assert property (@(posedge clk_sys) disable iff (reset)
        ce |=> (fractional_mode_q == ~$past(above250_q)))
        else $error("fractional mode wrong for vco range");

    spread_off_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && spread_amount_q == ccs_pkg::CCS_AMOUNT_BYPASS && !vco_bypass_select_q[1]) |=>
        (!spread_enable_q && spread_pos == 12'h000 && pll2_plain_enable_q))
        else $error("spread bypass left spread output running");

    spread_code_a: assert property (@(posedge clk_sys) disable iff (reset)
        (ce && reg_wr && reg_addr == ccs_pkg::CCS_BYTE_SPREAD) ##1 ce |=>
        (spread_center_q == !$past(reg_wr_data[6], 2)))
        else $error("spread amount code decoded wrongly");
endmodule // ccs_ctrl
`default_nettype wire

// File: bench/ccs_ref_model.sv
// reference source stand-in: drives the clock-select pin and tracks pll relock
`default_nettype none
module ccs_ref_model (
    // clock
    input wire logic clk_sys,
    // request from bench
    input wire logic want_secondary,
    // pin and lock status
    output logic multi_function_control_pin0,
    output logic relocked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] settle_q = 4'h0;
    logic pin_q = 1'b0;
    logic locked_q = 1'b1;
    // one process owns each value, the ports only mirror them
    assign multi_function_control_pin0 = pin_q;
    assign relocked = locked_q;
    // new reference may differ in frequency, so outputs are untrusted until relock
    always @(posedge clk_sys) begin
        if (want_secondary !== pin_q) begin
            pin_q <= want_secondary;
            settle_q <= 4'h8;
            locked_q <= 1'b0;
        end else if (settle_q != 4'h0) begin
            settle_q <= settle_q - 4'h1;
            locked_q <= (settle_q == 4'h1);
        end
    end
endmodule // ccs_ref_model
`default_nettype wire

// File: bench/tb_clock_input_pll_ssc_control.sv
// register-driven bench for the clock input, pll mode and spread control block
`default_nettype none
module tb_clock_input_pll_ssc_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, reset, ce, reg_wr, reg_rd, want_sec, relocked, pin0;
    logic [4:0] reg_addr;
    logic [7:0] reg_wr_data, reg_rd_data, rd_v;
    logic [1:0] src_q;
    logic sel_q, plain_q, spr_q, ctr_q;
    logic [2:0] speed_q, frac_q, byp_q, vbyp_q, pd_q;
    logic [8:0] span_q;
    logic [11:0] pos, top;
    int error_cnt, checks_done, cycles;
    logic [8:0] span_exp [8] = '{9'h000, 9'h00a, 9'h019, 9'h028, 9'h064, 9'h096, 9'h0c8, 9'h12c};

    ccs_ctrl ccs_ctrl_i (.clk_sys(clk_sys), .reset(reset), .ce(ce), .reg_addr(reg_addr),
        .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
        .multi_function_control_pin0(pin0), .ref_source_mode_q(src_q),
        .ref_input_select_q(sel_q), .vco_speed_range_select_q(speed_q),
        .fractional_mode_q(frac_q), .pll_bypass_q(byp_q), .vco_bypass_select_q(vbyp_q),
        .pll_power_down_q(pd_q), .pll2_plain_enable_q(plain_q), .spread_enable_q(spr_q),
        .spread_center_q(ctr_q), .spread_span_q(span_q), .spread_pos(pos), .spread_top(top));
    ccs_ref_model ccs_ref_model_i (.clk_sys(clk_sys), .want_secondary(want_sec),
        .multi_function_control_pin0(pin0), .relocked(relocked));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // returns once derived outputs of the write have landed
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wr_data <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rd_data;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard: whole sequence needs about a thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    initial begin
        {reset, ce, reg_wr, reg_rd, want_sec} = 5'h18;
        reg_addr = 5'h00;
        reg_wr_data = 8'h00;
        repeat (5) @(posedge clk_sys);
        reset <= 1'b0;
        tick(1);
        check("source", src_q, 2'h0);
        check("select", sel_q, 1'b0);
        check("spread en", spr_q, 1'b0);
        check("plain en", plain_q, 1'b1);
        rd(5'h19, rd_v);
        check("byte25", rd_v, 8'h09);
        $display("test reset done");
        for (int m = 0; m < 3; m++) begin
            wr(5'h0b, {m[1:0], 6'h00});
            check("source", src_q, m[1:0]);
            rd(5'h0b, rd_v);
            check("byte11", rd_v, {m[1:0], 6'h00});
        end
        wr(5'h0b, 8'h40);
        wr(5'h0a, 8'h10);
        check("select", sel_q, 1'b1);
        wr(5'h0a, 8'h00);
        check("select", sel_q, 1'b0);
        wr(5'h0a, 8'h02);
        @(posedge clk_sys);
        want_sec <= 1'b1;
        tick(12);
        check("pin select", sel_q, 1'b1);
        check("relocked", relocked, 1'b1);
        @(posedge clk_sys);
        want_sec <= 1'b0;
        tick(12);
        check("pin select", sel_q, 1'b0);
        check("relocked", relocked, 1'b1);
        $display("test input select done");
        wr(5'h0a, 8'h01);
        check("pin bypass", byp_q, 3'h7);
        wr(5'h0a, 8'h00);
        wr(5'h1b, 8'h28);
        check("pll bypass", byp_q, 3'h5);
        check("fractional", frac_q, 3'h7);
        // software flags pll2 above 250 so it runs integer ratios only
        wr(5'h1b, 8'h02);
        check("fractional", frac_q, 3'h5);
        wr(5'h06, 8'ha0);
        check("speed", speed_q, 3'h5);
        wr(5'h03, 8'h40);
        check("vco bypass", vbyp_q, 3'h2);
        tick(1);
        check("power down", pd_q, 3'h2);
        wr(5'h03, 8'h00);
        $display("test pll modes done");
        // pll2 vco kept low while spreading; amount changed only under bypass
        for (int a = 0; a < 8; a++) begin
            wr(5'h03, 8'h40);
            wr(5'h19, {1'b0, a[2:0], 4'hf});
            wr(5'h03, 8'h00);
            check("spread en", spr_q, a != 0);
            check("span", span_q, span_exp[a]);
            if (a != 0) check("center", ctr_q, a < 4);
            check("plain en", plain_q, 1'b1);
        end
        check("top", top, 12'h33e);
        for (int k = 0; k < 2000 && pos !== 12'h33e; k++) tick(1);
        check("peak", pos, 12'h33e);
        tick(1);
        check("falling", pos, 12'h33d);
        wr(5'h03, 8'h40);
        wr(5'h19, 8'h10);
        wr(5'h03, 8'h00);
        check("top", top, 12'hb18);
        // status: spread on, rising, primary, no power down, single-ended
        rd(5'h1c, rd_v);
        check("status", rd_v, 8'h81);
        wr(5'h1c, 8'h00);
        rd(5'h1c, rd_v);
        check("status kept", rd_v, 8'h81);
        $display("test spread done");
        @(posedge clk_sys);
        ce <= 1'b0;
        wr(5'h0b, 8'h80);
        @(posedge clk_sys);
        ce <= 1'b1;
        tick(2);
        check("frozen source", src_q, 2'h1);
        wr(5'h1d, 8'hff);
        rd(5'h1d, rd_v);
        check("unmapped", rd_v, 8'h00);
        $display("test freeze and unmapped done");
        // second reset in mid-run: fields and sweep must return to defaults
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        tick(1);
        check("source", src_q, 2'h0);
        check("fractional", frac_q, 3'h7);
        check("spread en", spr_q, 1'b0);
        check("pos", pos, 12'h000);
        check("top", top, 12'h66b);
        rd(5'h19, rd_v);
        check("byte25", rd_v, 8'h09);
        $display("test mid-run reset done");
        complete_run();
    end
endmodule // tb_clock_input_pll_ssc_control
`default_nettype wire
